// >>> hdl/fmd_top.v
// Freefall and motion event detector with its register port and interrupt.
//
// Overview of operation
// - Configuration bit 6 selects freefall (AND) or motion (OR) combining.
// - With all three axis enables clear the detector raises no events.
// - Latch bit 7 and combine bit select one of four modes.
// - Non-latched: event-active sets only after debounce count completes.
// - Only enabled axes take part in the freefall condition.
// - Non-latched decrement counter mode: event-active clears after counting back down.
// - Non-latched clear counter mode: flag drops at once, resets only after delay.
// - Non-latched: reading the source register leaves event-active alone.
// - Non-latched: axis flags follow raw per-axis condition, enabled only.
// - Latched: event-active sets at count and holds until source read.
// - Latched: source read clears flag and counter; new event needs delay.
// - Latched: while event-active clear, axis flags follow live condition.
// - Latched: axis flags freeze at event-active, resume after source read.
// - Freefall: every enabled axis magnitude at or below 7-bit threshold.
// - Motion: any enabled axis magnitude strictly above the threshold.
// - Counter mode 0 decrements on lapse, mode 1 clears to zero.
// - Polarity flag is 0 for positive g and 1 for negative g.
//
// The register offsets and the plain strobed port are this design's own decisions.
`default_nettype none
`include "fmd_regs.vh"
module fmd_top #(
  parameter SAMPLE_W = 8,
  parameter [31:0] TICK_CYCLES = `FMD_TICK_CYCLES
) (
  input wire clk_sys_i,
  input wire srst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wr_data_i,
  input wire wr_i,
  input wire rd_i,
  output wire [7:0] rd_data_o,
  input wire [SAMPLE_W-1:0] x_sample_i,
  input wire [SAMPLE_W-1:0] y_sample_i,
  input wire [SAMPLE_W-1:0] z_sample_i,
  output wire event_active_o,
  output wire odr_tick_o,
  output wire irq_o
);
  reg [7:0] cfg_ff;
  reg [7:0] ths_ff;
  reg [7:0] cnt_limit_ff;
  reg [7:0] dbc_ff;
  reg ea_ff;
  reg [5:0] flag_ff;
  reg [`FMD_IRQ_W-1:0] irq_stat_ff;
  reg [`FMD_IRQ_W-1:0] irq_mask_ff;
  reg [7:0] rd_data_ff;

  reg [7:0] step_dbc;
  reg [7:0] nxt_dbc;
  reg nxt_ea;
  reg [5:0] nxt_flag;
  reg [`FMD_IRQ_W-1:0] nxt_irq_stat;
  reg [7:0] nxt_rd_data;

  wire tick;
  wire [2:0] hit;
  wire [2:0] neg;

  wire event_latch_on = cfg_ff[`FMD_CFG_LATCH];
  wire motion_or_combine_select = cfg_ff[`FMD_CFG_OR_SEL];
  wire z_axis_event_enable = cfg_ff[`FMD_CFG_Z_EN];
  wire y_axis_event_enable = cfg_ff[`FMD_CFG_Y_EN];
  wire x_axis_event_enable = cfg_ff[`FMD_CFG_X_EN];
  wire [2:0] axis_en = {z_axis_event_enable, y_axis_event_enable,
                        x_axis_event_enable};
  wire debounce_counter_mode = ths_ff[`FMD_THS_DBC_MODE];
  wire [6:0] event_threshold = ths_ff[`FMD_THS_MSB:0];
  wire any_en = |axis_en;

  // One address compare shared by every strobe decode below.
  function addr_is;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  fmd_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_div (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .tick_o(tick)
  );

  fmd_axis_cmp #(.SAMPLE_W(SAMPLE_W)) u_x (
    .sample_i(x_sample_i),
    .thresh_i(event_threshold),
    .enable_i(x_axis_event_enable),
    .or_sel_i(motion_or_combine_select),
    .hit_o(hit[0]),
    .neg_o(neg[0])
  );

  fmd_axis_cmp #(.SAMPLE_W(SAMPLE_W)) u_y (
    .sample_i(y_sample_i),
    .thresh_i(event_threshold),
    .enable_i(y_axis_event_enable),
    .or_sel_i(motion_or_combine_select),
    .hit_o(hit[1]),
    .neg_o(neg[1])
  );

  fmd_axis_cmp #(.SAMPLE_W(SAMPLE_W)) u_z (
    .sample_i(z_sample_i),
    .thresh_i(event_threshold),
    .enable_i(z_axis_event_enable),
    .or_sel_i(motion_or_combine_select),
    .hit_o(hit[2]),
    .neg_o(neg[2])
  );

  // Disabled axes count as satisfied in the AND so they cannot veto it.
  wire and_cond = &(hit | ~axis_en);
  wire or_cond = |hit;
  wire cond = any_en & (motion_or_combine_select ? or_cond : and_cond);

  // Strobes are single cycles, so each decode is a one-cycle pulse.
  wire src_rd = rd_i && addr_is(addr_i, `FMD_ADDR_SRC);
  wire reg_wr_cfg = wr_i && addr_is(addr_i, `FMD_ADDR_CFG);
  wire reg_wr_ths = wr_i && addr_is(addr_i, `FMD_ADDR_THS);
  wire reg_wr_cnt = wr_i && addr_is(addr_i, `FMD_ADDR_CNT);
  wire reg_wr_stat = wr_i && addr_is(addr_i, `FMD_ADDR_IRQ_STAT);
  wire reg_wr_mask = wr_i && addr_is(addr_i, `FMD_ADDR_IRQ_MASK);

  // Live per-axis flags in source-register order, polarity from the sign.
  wire [5:0] live_flag = {hit[2], neg[2], hit[1], neg[1], hit[0], neg[0]};

  // Debounce counter step, one move per sample tick.
  always @* begin
    step_dbc = dbc_ff;
    if (!any_en) begin
      step_dbc = 8'h00;
    end else if (tick) begin
      if (cond) begin
        if (dbc_ff < cnt_limit_ff) begin
          step_dbc = dbc_ff + 8'h01;
        end
      end else if (debounce_counter_mode) begin
        step_dbc = 8'h00;
      end else if (dbc_ff != 8'h00) begin
        step_dbc = dbc_ff - 8'h01;
      end
    end
  end

  wire ea_set = tick && cond && (step_dbc >= cnt_limit_ff);
  // A source read in latched mode acknowledges; a set in the same cycle wins.
  wire ack = src_rd && event_latch_on && !ea_set;

  always @* begin
    nxt_dbc = ack ? 8'h00 : step_dbc;
    nxt_ea = ea_ff;
    if (!any_en) begin
      nxt_ea = 1'b0;
    end else if (ea_set) begin
      nxt_ea = 1'b1;
    end else if (event_latch_on) begin
      if (ack) begin
        nxt_ea = 1'b0;
      end
    end else if (tick) begin
      // Non-latched release; source reads play no part here.
      if (debounce_counter_mode) begin
        if (!cond) begin
          nxt_ea = 1'b0;
        end
      end else if (step_dbc == 8'h00) begin
        nxt_ea = 1'b0;
      end
    end
  end

  always @* begin
    nxt_flag = flag_ff;
    if (!event_latch_on) begin
      if (tick) begin
        nxt_flag = live_flag;
      end
    end else if (ack) begin
      nxt_flag = 6'h00;
    end else if (!ea_ff && tick) begin
      // The set tick itself captures the flags that caused the event.
      nxt_flag = live_flag;
    end
  end

  wire ea_rise = nxt_ea && !ea_ff;
  wire ea_fall = !nxt_ea && ea_ff;
  wire [`FMD_IRQ_W-1:0] irq_evt = {ea_fall, ea_rise};
  wire [`FMD_IRQ_W-1:0] irq_w1c = reg_wr_stat ? wr_data_i[`FMD_IRQ_W-1:0]
                                              : {`FMD_IRQ_W{1'b0}};

  always @* begin
    // New events win over a write-one-to-clear in the same cycle.
    nxt_irq_stat = (irq_stat_ff & ~irq_w1c) | irq_evt;
  end

  // Disabled axes always read zero, even while latched.
  wire [5:0] src_axes = flag_ff & {{2{axis_en[2]}}, {2{axis_en[1]}},
                                   {2{axis_en[0]}}};

  // Whole read words, assembled once so the mux below stays flat.
  wire [7:0] src_word = {ea_ff, 1'b0, src_axes};
  wire [7:0] stat_word = {6'h00, irq_stat_ff};
  wire [7:0] mask_word = {6'h00, irq_mask_ff};
  wire [7:0] live_word = {cond, 1'b0, live_flag};

  // Idle cycles return zero, so a stale word never lingers on the bus.
  always @* begin
    nxt_rd_data = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `FMD_ADDR_CFG: begin
          nxt_rd_data = cfg_ff;
        end
        `FMD_ADDR_SRC: begin
          nxt_rd_data = src_word;
        end
        `FMD_ADDR_THS: begin
          nxt_rd_data = ths_ff;
        end
        `FMD_ADDR_CNT: begin
          nxt_rd_data = cnt_limit_ff;
        end
        `FMD_ADDR_IRQ_STAT: begin
          nxt_rd_data = stat_word;
        end
        `FMD_ADDR_IRQ_MASK: begin
          nxt_rd_data = mask_word;
        end
        `FMD_ADDR_DBC: begin
          nxt_rd_data = dbc_ff;
        end
        `FMD_ADDR_LIVE: begin
          nxt_rd_data = live_word;
        end
        default: begin
          nxt_rd_data = 8'h00;
        end
      endcase
    end
  end

  // Configuration: the three reserved low bits always read zero.
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      cfg_ff <= `FMD_RST_CFG;
    end else if (reg_wr_cfg) begin
      cfg_ff <= wr_data_i & `FMD_CFG_WMASK;
    end
  end

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      ths_ff <= `FMD_RST_THS;
    end else if (reg_wr_ths) begin
      ths_ff <= wr_data_i;
    end
  end

  // A new limit takes effect at the next tick; the count is not rescaled.
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      cnt_limit_ff <= `FMD_RST_CNT;
    end else if (reg_wr_cnt) begin
      cnt_limit_ff <= wr_data_i;
    end
  end

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      irq_mask_ff <= `FMD_RST_MASK;
    end else if (reg_wr_mask) begin
      irq_mask_ff <= wr_data_i[`FMD_IRQ_W-1:0];
    end
  end

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      dbc_ff <= 8'h00;
    end else begin
      dbc_ff <= nxt_dbc;
    end
  end

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      ea_ff <= 1'b0;
    end else begin
      ea_ff <= nxt_ea;
    end
  end

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      flag_ff <= 6'h00;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      irq_stat_ff <= {`FMD_IRQ_W{1'b0}};
    end else begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data_o = rd_data_ff;
  assign event_active_o = ea_ff;
  assign odr_tick_o = tick;
  assign irq_o = |(irq_stat_ff & irq_mask_ff);
endmodule // fmd_top
`default_nettype wire

// >>> hdl/fmd_regs.vh
// Register map, field positions, reset values and timing of the detector.
`ifndef FMD_REGS_VH
`define FMD_REGS_VH

// Register byte addresses.
`define FMD_ADDR_CFG 8'h15
`define FMD_ADDR_SRC 8'h16
`define FMD_ADDR_THS 8'h17
`define FMD_ADDR_CNT 8'h18
`define FMD_ADDR_IRQ_STAT 8'h19
`define FMD_ADDR_IRQ_MASK 8'h1a
`define FMD_ADDR_DBC 8'h1b
`define FMD_ADDR_LIVE 8'h1c

// Configuration register fields.
`define FMD_CFG_LATCH 7
`define FMD_CFG_OR_SEL 6
`define FMD_CFG_Z_EN 5
`define FMD_CFG_Y_EN 4
`define FMD_CFG_X_EN 3
`define FMD_CFG_WMASK 8'hf8

// Source register fields.
`define FMD_SRC_EA 7
`define FMD_SRC_Z_EVT 5
`define FMD_SRC_Z_POL 4
`define FMD_SRC_Y_EVT 3
`define FMD_SRC_Y_POL 2
`define FMD_SRC_X_EVT 1
`define FMD_SRC_X_POL 0

// Threshold register fields.
`define FMD_THS_DBC_MODE 7
`define FMD_THS_MSB 6

// Interrupt status and mask fields.
`define FMD_IRQ_EA_RISE 0
`define FMD_IRQ_EA_FALL 1
`define FMD_IRQ_W 2

// Reset values.
`define FMD_RST_CFG 8'h00
`define FMD_RST_THS 8'h00
`define FMD_RST_CNT 8'h00
`define FMD_RST_MASK 2'h0

// Timing: system clock and output data rate.
`define FMD_CLK_HZ 125000000
`define FMD_ODR_HZ 800
`define FMD_TICK_CYCLES (`FMD_CLK_HZ / `FMD_ODR_HZ)

`endif

// >>> hdl/fmd_tick_div.v
// Output-data-rate divider: one-cycle sample tick from the system clock.
`default_nettype none
`include "fmd_regs.vh"
module fmd_tick_div #(
  parameter [31:0] TICK_CYCLES = `FMD_TICK_CYCLES
) (
  input wire clk_sys_i,
  input wire srst_i,
  output wire tick_o
);
  reg [31:0] cnt_ff;
  wire last = (cnt_ff == TICK_CYCLES - 32'h1) || (TICK_CYCLES < 32'h2);

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      cnt_ff <= 32'h0;
    end else if (last) begin
      cnt_ff <= 32'h0;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end

  assign tick_o = last;
endmodule // fmd_tick_div
`default_nettype wire

// >>> hdl/fmd_axis_cmp.v
// One axis: magnitude against threshold, with polarity, gated by enable.
`default_nettype none
module fmd_axis_cmp #(
  parameter SAMPLE_W = 8
) (
  input wire [SAMPLE_W-1:0] sample_i,
  input wire [6:0] thresh_i,
  input wire enable_i,
  input wire or_sel_i,
  output wire hit_o,
  output wire neg_o
);
  wire sign = sample_i[SAMPLE_W-1];
  // One extra bit so the most negative sample has a true magnitude.
  wire [SAMPLE_W:0] mag = sign ? ({1'b0, ~sample_i} + 1'b1)
                               : {1'b0, sample_i};
  wire [SAMPLE_W:0] thr = {{(SAMPLE_W-6){1'b0}}, thresh_i};
  wire above = mag > thr;

  assign hit_o = enable_i & (or_sel_i ? above : ~above);
  assign neg_o = hit_o & sign;
endmodule // fmd_axis_cmp
`default_nettype wire

// >>> test/fmd_sva.sv
// Port-level assertions for the freefall and motion event detector.
`default_nettype none
module fmd_sva #(
  parameter int TICK_CYCLES = 8
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rd_data_o,
  input wire logic event_active_o,
  input wire logic odr_tick_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  logic [31:0] div_ff;
  // A private divider, so a wrong tick spacing cannot hide behind the DUT.
  always @(posedge clk_sys_i) begin
    if (srst_i || div_ff == TICK_CYCLES - 1) div_ff <= 0;
    else div_ff <= div_ff + 1;
  end
  property p_tick_gap;
    odr_tick_o == (div_ff == TICK_CYCLES - 1);
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("sample tick spacing wrong");
  property p_ea_rise;
    $rose(event_active_o) |-> $past(odr_tick_o);
  endproperty
  a_ea_rise: assert property (p_ea_rise)
    else $error("event active rose off a tick");
  property p_ea_fall;
    $fell(event_active_o) |->
      $past(odr_tick_o) || ($past(rd_i) && $past(addr_i) == 8'h16);
  endproperty
  a_ea_fall: assert property (p_ea_fall)
    else $error("event active fell without tick or read");
  property p_ea_hold;
    event_active_o && !odr_tick_o && !rd_i |=> event_active_o;
  endproperty
  a_ea_hold: assert property (p_ea_hold)
    else $error("event active dropped between ticks");
  property p_src_ea;
    rd_i && addr_i == 8'h16 |=>
      rd_data_o[7] == $past(event_active_o) && !rd_data_o[6];
  endproperty
  a_src_ea: assert property (p_src_ea)
    else $error("source read shows wrong event bit");
  property p_cfg_low;
    rd_i && addr_i == 8'h15 |=> rd_data_o[2:0] == 3'h0;
  endproperty
  a_cfg_low: assert property (p_cfg_low)
    else $error("config low bits not zero");
  property p_rd_idle;
    !rd_i |=> rd_data_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
  property p_irq_rise;
    $rose(irq_o) |-> $past(odr_tick_o) || $past(wr_i) || $past(rd_i) ||
      $past(rd_i, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt rose without cause");
  property p_irq_fall;
    $fell(irq_o) |-> $past(wr_i);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt fell without write");
  c_ea: cover property ($rose(event_active_o));
  c_ack: cover property (event_active_o && rd_i && addr_i == 8'h16);
  c_irq: cover property ($rose(irq_o));
endmodule // fmd_sva
`default_nettype wire

// >>> test/fmd_host.sv
// Host processor model: register bus master of the detector.
`default_nettype none
module fmd_host (
  input wire logic clk_sys_i,
  output var logic [7:0] addr_o = 8'h00,
  output var logic [7:0] wr_data_o = 8'h00,
  output var logic wr_o = 1'b0,
  output var logic rd_o = 1'b0,
  input wire logic [7:0] rd_data_i
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    wr_data_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe, so take them there.
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    #1;
    q = rd_data_i;
  endtask
endmodule // fmd_host
`default_nettype wire

// >>> test/freefall_motion_event_detector_bench.sv
// Self-checking bench of the detector against a behavioural model.
`default_nettype none
module freefall_motion_event_detector_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] xs = 8'h00, ys = 8'h00, zs = 8'h00, q;
  wire [7:0] addr, wdat, rdat;
  wire wr, rd, ea, tick, irq;
  int miscompares = 0, check_count = 0, seed = 32'hff89, w, en;
  int m_cfg, m_thr, m_mode, m_lim, m_cnt, m_ea, m_fl, m_stat, m_mask;
  logic [7:0] m_fl_a [8] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a,
    8'h1b, 8'h30};
  fmd_top #(.TICK_CYCLES(8)) fmd_top_i (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .addr_i(addr), .wr_data_i(wdat), .wr_i(wr),
    .rd_i(rd), .rd_data_o(rdat), .x_sample_i(xs), .y_sample_i(ys),
    .z_sample_i(zs), .event_active_o(ea), .odr_tick_o(tick), .irq_o(irq));
  fmd_host fmd_host_i (.clk_sys_i(clk_sys_i), .addr_o(addr),
    .wr_data_o(wdat), .wr_o(wr), .rd_o(rd), .rd_data_i(rdat));
  initial forever #4 clk_sys_i = ~clk_sys_i;
  task automatic chk(input string nm, input logic [7:0] s, e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize;
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic rst;
    @(posedge clk_sys_i) srst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    m_cnt = 0;
    m_ea = 0;
    m_fl = 0;
    m_stat = 0;
  endtask
  // One sample tick of the detector, reading the samples it just took.
  task automatic mstep;
    logic signed [7:0] s [3];
    int mag, h, n, c, pea;
    s = '{xs, ys, zs};
    h = 0;
    n = 0;
    pea = m_ea;
    for (int i = 0; i < 3; i++) begin
      mag = s[i] < 0 ? -s[i] : s[i];
      if (en[i] && (m_cfg[6] ? mag > m_thr : mag <= m_thr)) begin
        h[i] = 1;
        n[i] = s[i] < 0;
      end
    end
    c = m_cfg[6] ? h != 0 : h == en;
    if (en == 0) begin
      m_cnt = 0;
      m_ea = 0;
    end else if (c) begin
      if (m_cnt < m_lim) m_cnt++;
      if (m_cnt >= m_lim) m_ea = 1;
    end else begin
      m_cnt = (m_mode || m_cnt == 0) ? 0 : m_cnt - 1;
      if (!m_cfg[7] && m_cnt == 0) m_ea = 0;
    end
    if (!(m_cfg[7] && pea)) m_fl = {h[2], n[2], h[1], n[1], h[0], n[0]};
    if (m_ea && !pea) m_stat |= 1;
    if (!m_ea && pea) m_stat |= 2;
  endtask
  initial begin
    rst();
    foreach (m_fl_a[i]) begin
      fmd_host_i.rd(m_fl_a[i], q);
      chk("reset value", q, 8'h00);
    end
    for (int k = 0; k < 16; k++) begin
      rst();
      en = k < 2 ? 0 : ($random(seed) & 7) | (1 << k % 3);
      m_thr = $random(seed) & 31;
      m_mode = (k >> 2) & 1;
      m_lim = $random(seed) & 3;
      m_mask = $random(seed) & 3;
      m_cfg = ((k & 1) << 7) | (((k >> 1) & 1) << 6) | (en << 3);
      fmd_host_i.wr(8'h17, (m_mode << 7) | m_thr);
      fmd_host_i.wr(8'h18, m_lim);
      fmd_host_i.wr(8'h1a, m_mask);
      fmd_host_i.wr(8'h15, m_cfg);
      repeat (40) begin
        @(negedge clk_sys_i);
        while (tick !== 1'b1) @(negedge clk_sys_i);
        @(posedge clk_sys_i);
        mstep();
        if ($random(seed) & 1) begin
          xs <= $random(seed) % 48;
          ys <= $random(seed) % 48;
          zs <= $random(seed) % 48;
        end
        #1;
        chk("event active", ea, m_ea);
        chk("irq", irq, (m_stat & m_mask) != 0);
        if ($random(seed) & 1) begin
          fmd_host_i.rd(8'h16, q);
          chk("source", q, {m_ea[0], 1'b0, m_fl[5:0]});
          if (m_cfg[7]) begin
            if (m_ea) m_stat |= 2;
            m_ea = 0;
            m_cnt = 0;
            m_fl = 0;
          end
          w = $random(seed) & 3;
          fmd_host_i.wr(8'h19, w);
          m_stat &= ~w;
        end
      end
    end
    summarize();
  end
  // A stuck handshake or a lost tick would otherwise hang the run.
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
endmodule // freefall_motion_event_detector_bench
bind fmd_top fmd_sva #(.TICK_CYCLES(TICK_CYCLES)) fmd_sva_i (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i), .wr_i(wr_i),
  .rd_i(rd_i), .rd_data_o(rd_data_o), .event_active_o(event_active_o),
  .odr_tick_o(odr_tick_o), .irq_o(irq_o));
`default_nettype wire
